// [standby_pin_defines.svh]
// Offsets, field positions, reset values and pin roles of the standby pin block
`ifndef STANDBY_PIN_DEFINES_SVH
`define STANDBY_PIN_DEFINES_SVH

`define SPC_NPINS 8
`define SPC_OFF_CTRL 8'h00
`define SPC_OFF_PORT_OUT 8'h04
`define SPC_OFF_PORT_DIR 8'h08
`define SPC_OFF_PULLUP 8'h0C
`define SPC_OFF_PORT_IN 8'h10
`define SPC_OFF_FUNC 8'h14
`define SPC_OFF_EXTINT_EN 8'h18
`define SPC_OFF_TOUCH_SEL 8'h1C
`define SPC_OFF_STATUS 8'h20

`define SPC_CTRL_FLOAT_BIT 0
`define SPC_CTRL_MODE_LSB 1
`define SPC_FUNC_CMP_OUT 0
`define SPC_FUNC_BEEP 1
`define SPC_FUNC_TSC_DOUT 2
`define SPC_FUNC_TSC_RUN 3
`define SPC_FUNC_CMP_IRQ 4
`define SPC_FUNC_TOUCH_IRQ 5

`define SPC_RESET_BYTE 8'h00
`define SPC_PIN_CMP_OUT 0
`define SPC_PIN_BEEP 1
`define SPC_PIN_TSC_DOUT 2
`define SPC_TOUCH_MASK 8'hF0

`define SPC_RESP_OKAY 2'h0
`define SPC_RESP_SLVERR 2'h2

`endif

// [standby_pin_pkg.sv]
// Types shared by the standby pin block and its bus slave
`default_nettype none
package standby_pin_pkg;

  typedef enum logic [1:0] {
    mode_normal = 2'h0,
    mode_sleep = 2'h1,
    mode_stop = 2'h2,
    mode_watch = 2'h3
  } mode_req_e;

  typedef enum logic [3:0] {
    st_normal = 4'h1,
    st_sleep = 4'h2,
    st_stop = 4'h4,
    st_watch = 4'h8
  } power_state_e;

  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_wr_s;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pu;
  } pin_drive_s;

endpackage
`default_nettype wire

// [standby_axil_slave.sv]
// AXI4-Lite slave front end for the standby pin registers
`timescale 1ns/10ps
`default_nettype none
`include "standby_pin_defines.svh"

module standby_axil_slave
  import standby_pin_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write channels
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read channels
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Register side
  output reg_wr_s wr,
  input wire logic wr_ok,
  input wire logic [7:0] rd_byte,
  input wire logic rd_ok
);

  logic next_awready;
  logic next_wready;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_arready;
  logic next_rvalid;
  logic [1:0] next_rresp;
  logic [31:0] next_rdata;
  logic wr_take;
  logic rd_take;

  // Both write items taken together, one at a time
  assign wr_take = awvalid && wvalid && !bvalid && !awready;
  assign rd_take = arvalid && !rvalid && !arready;
  assign wr.en = wr_take && wstrb[0];
  assign wr.addr = awaddr;
  assign wr.data = wdata[7:0];

  always_comb
  begin
    next_awready = wr_take;
    next_wready = wr_take;
    next_bvalid = bvalid;
    next_bresp = bresp;
    if (wr_take)
    begin
      next_bvalid = 1'b1;
      next_bresp = wr_ok ? `SPC_RESP_OKAY : `SPC_RESP_SLVERR;
    end
    else if (bvalid && bready)
      next_bvalid = 1'b0;
    next_arready = rd_take;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    if (rd_take)
    begin
      next_rvalid = 1'b1;
      next_rresp = rd_ok ? `SPC_RESP_OKAY : `SPC_RESP_SLVERR;
      next_rdata = {24'h000000, rd_byte};
    end
    else if (rvalid && rready)
      next_rvalid = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `SPC_RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rresp <= `SPC_RESP_OKAY;
      rdata <= 32'h00000000;
    end
    else
    begin
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end

endmodule
`default_nettype wire

// [standby_pin_state_control.sv]
// Standby pin state control: port pins across run, sleep, stop, watch and reset
//
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "standby_pin_defines.svh"

// Function
// [RULE1] Stop/watch: float bit 0 holds last output, 1 floats the pin.
// [RULE2] Blocked pins feed no direct input into internal logic.
// [RULE3] Standby and reset pin states apply to pins used as ports.
// [RULE4] In reset pins float, input seen but drives no function.
// [RULE5] Board must pull enabled inputs up or down to avoid leakage.
// [RULE6] Input-enabled pin used as output behaves like any output.
// [RULE7] Floated pins keep configured pull-up in force.
// [RULE8] Enabled external interrupts still detected while input blocked.
// [RULE9] Enabled comparator interrupt still raised while input blocked.
// [RULE10] Comparator output pin drives in standby only if bit 0 and enabled.
// [RULE11] Beep pin drives in standby only if bit 0 and beep enabled.
// [RULE12] Touch direct output drives in standby only if bit 0 and enabled.
// [RULE13] Touch pin outputs sense clock when controller runs, else follows bit.
// [RULE14] Enabled touch interrupt still raised while input blocked.
// [RULE15] Input-enabled pin passes its level to the selected function.
// [RULE16] Sleep behaves exactly like normal operation on the pins.
// [RULE17] Standby states apply on stop/watch entry, revert on wake-up.
module standby_pin_state_control
  import standby_pin_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite register bus
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Pins
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] pin_pullup,
  // Peripheral outputs routed to pins
  input wire logic cmp_out_sig,
  input wire logic beep_sig,
  input wire logic tsc_dout_sig,
  input wire logic sense_clock_out,
  // Event sources
  input wire logic cmp_analog_event,
  input wire logic [7:0] touch_signal,
  input wire logic wake_req,
  // Gated inputs and interrupt requests
  output logic [7:0] func_in,
  output logic [7:0] ext_irq_req,
  output logic cmp_irq,
  output logic touch_irq,
  output logic in_standby
);

  reg_wr_s wr;
  logic wr_ok;
  logic rd_ok;
  logic [7:0] rd_byte;

  // Control registers
  logic standby_pin_float_select;
  logic [7:0] port_out;
  logic [7:0] port_dir;
  logic [7:0] pullup_en;
  logic [7:0] func_ctrl;
  logic [7:0] extint_en;
  logic [7:0] touch_sel;
  logic next_float;
  logic [7:0] next_port_out;
  logic [7:0] next_port_dir;
  logic [7:0] next_pullup_en;
  logic [7:0] next_func_ctrl;
  logic [7:0] next_extint_en;
  logic [7:0] next_touch_sel;

  // Power state and held pin image
  power_state_e state;
  power_state_e next_state;
  pin_drive_s held;
  pin_drive_s next_held;
  pin_drive_s run_drive;
  pin_drive_s next_drive;
  logic mode_wr;
  mode_req_e mode_req;
  logic standby;
  logic wake;

  // Input side
  logic [7:0] pin_prev;
  logic [7:0] touch_prev;
  logic [7:0] next_func_in;
  logic [7:0] next_ext_irq;
  logic next_cmp_irq;
  logic next_touch_irq;

  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == `SPC_OFF_CTRL) || (a == `SPC_OFF_PORT_OUT) ||
      (a == `SPC_OFF_PORT_DIR) || (a == `SPC_OFF_PULLUP) ||
      (a == `SPC_OFF_PORT_IN) || (a == `SPC_OFF_FUNC) ||
      (a == `SPC_OFF_EXTINT_EN) || (a == `SPC_OFF_TOUCH_SEL) ||
      (a == `SPC_OFF_STATUS);
  endfunction

  standby_axil_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .wr(wr),
    .wr_ok(wr_ok),
    .rd_byte(rd_byte),
    .rd_ok(rd_ok)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register writes and reads

  assign wr_ok = addr_known(wr.addr);
  assign rd_ok = addr_known(araddr);
  assign mode_wr = wr.en && (wr.addr == `SPC_OFF_CTRL);
  assign mode_req = mode_req_e'(wr.data[`SPC_CTRL_MODE_LSB +: 2]);
  assign standby = (state == st_stop) || (state == st_watch);

  always_comb
  begin
    next_float = standby_pin_float_select;
    next_port_out = port_out;
    next_port_dir = port_dir;
    next_pullup_en = pullup_en;
    next_func_ctrl = func_ctrl;
    next_extint_en = extint_en;
    next_touch_sel = touch_sel;
    if (wr.en)
    begin
      case (wr.addr)
        `SPC_OFF_CTRL: next_float = wr.data[`SPC_CTRL_FLOAT_BIT];
        `SPC_OFF_PORT_OUT: next_port_out = wr.data;
        `SPC_OFF_PORT_DIR: next_port_dir = wr.data;
        `SPC_OFF_PULLUP: next_pullup_en = wr.data;
        `SPC_OFF_FUNC: next_func_ctrl = wr.data;
        `SPC_OFF_EXTINT_EN: next_extint_en = wr.data;
        `SPC_OFF_TOUCH_SEL: next_touch_sel = wr.data;
        default: next_float = standby_pin_float_select;
      endcase
    end
  end

  always_comb
  begin
    case (araddr)
      `SPC_OFF_CTRL: rd_byte = {5'h00, state == st_watch || state == st_stop,
        state == st_watch || state == st_sleep, standby_pin_float_select};
      `SPC_OFF_PORT_OUT: rd_byte = port_out;
      `SPC_OFF_PORT_DIR: rd_byte = port_dir;
      `SPC_OFF_PULLUP: rd_byte = pullup_en;
      `SPC_OFF_PORT_IN: rd_byte = func_in;
      `SPC_OFF_FUNC: rd_byte = func_ctrl;
      `SPC_OFF_EXTINT_EN: rd_byte = extint_en;
      `SPC_OFF_TOUCH_SEL: rd_byte = touch_sel;
      `SPC_OFF_STATUS: rd_byte = {4'h0, state};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      standby_pin_float_select <= 1'b0;
      port_out <= `SPC_RESET_BYTE;
      port_dir <= `SPC_RESET_BYTE;
      pullup_en <= `SPC_RESET_BYTE;
      func_ctrl <= `SPC_RESET_BYTE;
      extint_en <= `SPC_RESET_BYTE;
      touch_sel <= `SPC_RESET_BYTE;
    end
    else
    begin
      standby_pin_float_select <= next_float;
      port_out <= next_port_out;
      port_dir <= next_port_dir;
      pullup_en <= next_pullup_en;
      func_ctrl <= next_func_ctrl;
      extint_en <= next_extint_en;
      touch_sel <= next_touch_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power state; pin image frozen on stop or watch entry

  assign wake = wake_req || (|ext_irq_req) || cmp_irq || touch_irq;

  always_comb
  begin
    next_state = state;
    case (state)
      st_normal, st_sleep:
      begin
        if (mode_wr)
        begin
          case (mode_req)
            mode_sleep: next_state = st_sleep;
            mode_stop: next_state = st_stop;
            mode_watch: next_state = st_watch;
            default: next_state = st_normal;
          endcase
        end
        else if (state == st_sleep && wake)
          next_state = st_normal;
      end
      st_stop, st_watch:
      begin
        if (wake)
          next_state = st_normal; // RULE17
      end
      default: next_state = st_normal;
    endcase
  end

  // Normal and sleep drive the same image
  always_comb
  begin
    run_drive.out = port_out; // RULE6
    run_drive.oe = port_dir; // RULE16
    run_drive.pu = pullup_en;
    if (func_ctrl[`SPC_FUNC_CMP_OUT])
    begin
      run_drive.out[`SPC_PIN_CMP_OUT] = cmp_out_sig;
      run_drive.oe[`SPC_PIN_CMP_OUT] = 1'b1;
    end
    if (func_ctrl[`SPC_FUNC_BEEP])
    begin
      run_drive.out[`SPC_PIN_BEEP] = beep_sig;
      run_drive.oe[`SPC_PIN_BEEP] = 1'b1;
    end
    if (func_ctrl[`SPC_FUNC_TSC_DOUT])
    begin
      run_drive.out[`SPC_PIN_TSC_DOUT] = tsc_dout_sig;
      run_drive.oe[`SPC_PIN_TSC_DOUT] = 1'b1;
    end
  end

  always_comb
  begin
    next_held = held;
    if (!standby && (next_state == st_stop || next_state == st_watch))
      next_held = run_drive; // RULE17
    next_drive = run_drive;
    if (standby)
    begin
      next_drive.pu = pullup_en; // RULE7
      next_drive.out = held.out; // RULE3
      next_drive.oe = standby_pin_float_select ? 8'h00 : held.oe; // RULE1
      if (!standby_pin_float_select && func_ctrl[`SPC_FUNC_CMP_OUT])
        next_drive.out[`SPC_PIN_CMP_OUT] = cmp_out_sig; // RULE10
      else if (func_ctrl[`SPC_FUNC_CMP_OUT])
        next_drive.oe[`SPC_PIN_CMP_OUT] = 1'b0; // RULE10
      if (!standby_pin_float_select && func_ctrl[`SPC_FUNC_BEEP])
        next_drive.out[`SPC_PIN_BEEP] = beep_sig; // RULE11
      else if (func_ctrl[`SPC_FUNC_BEEP])
        next_drive.oe[`SPC_PIN_BEEP] = 1'b0; // RULE11
      if (!standby_pin_float_select && func_ctrl[`SPC_FUNC_TSC_DOUT])
        next_drive.out[`SPC_PIN_TSC_DOUT] = tsc_dout_sig; // RULE12
      else if (func_ctrl[`SPC_FUNC_TSC_DOUT])
        next_drive.oe[`SPC_PIN_TSC_DOUT] = 1'b0; // RULE12
      if (func_ctrl[`SPC_FUNC_TSC_RUN])
      begin
        for (int i = 0; i < `SPC_NPINS; i++)
        begin
          if (touch_sel[i] && ((`SPC_TOUCH_MASK & (8'h01 << i)) != 8'h00))
          begin
            next_drive.out[i] = sense_clock_out; // RULE13
            next_drive.oe[i] = 1'b1; // RULE13
          end
        end
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= st_normal;
      held <= '0;
      pin_out <= 8'h00;
      pin_oe <= 8'h00; // RULE4
      pin_pullup <= 8'h00;
      in_standby <= 1'b0;
    end
    else
    begin
      state <= next_state;
      held <= next_held;
      pin_out <= next_drive.out;
      pin_oe <= next_drive.oe;
      pin_pullup <= next_drive.pu;
      in_standby <= standby;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input gates and wake-capable events

  always_comb
  begin
    next_func_in = standby ? 8'h00 : pin_in; // RULE2 RULE15
    next_ext_irq = extint_en & pin_in & ~pin_prev; // RULE8
    next_cmp_irq = cmp_analog_event && func_ctrl[`SPC_FUNC_CMP_IRQ]; // RULE9
    next_touch_irq = func_ctrl[`SPC_FUNC_TOUCH_IRQ] &&
      (|(touch_sel & `SPC_TOUCH_MASK & touch_signal & ~touch_prev)); // RULE14
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_prev <= 8'h00;
      touch_prev <= 8'h00;
      func_in <= 8'h00; // RULE4
      ext_irq_req <= 8'h00;
      cmp_irq <= 1'b0;
      touch_irq <= 1'b0;
    end
    else
    begin
      pin_prev <= pin_in;
      touch_prev <= touch_signal;
      func_in <= next_func_in;
      ext_irq_req <= next_ext_irq;
      cmp_irq <= next_cmp_irq;
      touch_irq <= next_touch_irq;
    end
  end

endmodule
`default_nettype wire

// [standby_pin_chk.sv]
// Checker for the standby pin state control ports
`timescale 1ns/10ps
`default_nettype none
module standby_pin_chk
  import standby_pin_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Watched ports
  input wire logic bvalid,
  input wire logic wake_req,
  input wire logic cmp_analog_event,
  input wire logic cmp_irq,
  input wire logic touch_irq,
  input wire logic in_standby,
  input wire logic [7:0] pin_in,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup,
  input wire logic [7:0] touch_signal,
  input wire logic [7:0] func_in,
  input wire logic [7:0] ext_irq_req
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_held;
    in_standby && $past(in_standby);
  endsequence
  sequence s_wake;
    in_standby && wake_req;
  endsequence

  chk_reset_hiz: assert property ($rose(aresetn) |-> pin_oe == 8'h00 && func_in == 8'h00)
    else $error("pins not floated by reset");
  chk_input_gate: assert property (in_standby |-> func_in == 8'h00)
    else $error("input gate open in standby");
  chk_port_hold: assert property (s_held |-> $stable(pin_out[3]) && $stable(pin_oe[3]))
    else $error("port pin moved in standby");
  chk_pullup_kept: assert property (s_held ##0 !bvalid |-> $stable(pin_pullup))
    else $error("pull-up changed in standby");
  chk_ext_edge: assert property (ext_irq_req != 8'h00 |->
    (ext_irq_req & ~($past(pin_in) & ~$past(pin_in, 2))) == 8'h00)
    else $error("external request without rising pin");
  chk_cmp_cause: assert property (cmp_irq |-> $past(cmp_analog_event))
    else $error("comparator request without event");
  chk_touch_cause: assert property (touch_irq |->
    |($past(touch_signal[7:4]) & ~$past(touch_signal[7:4], 2)))
    else $error("touch request without rising touch");
  chk_wake_exit: assert property (s_wake |-> ##2 !in_standby)
    else $error("standby not left on wake");
endmodule

bind standby_pin_state_control standby_pin_chk i_standby_pin_chk (.aclk(aclk),
  .aresetn(aresetn), .bvalid(bvalid), .wake_req(wake_req), .cmp_analog_event(cmp_analog_event),
  .cmp_irq(cmp_irq), .touch_irq(touch_irq), .in_standby(in_standby), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup), .touch_signal(touch_signal),
  .func_in(func_in), .ext_irq_req(ext_irq_req));
`default_nettype wire

// [standby_board_model.sv]
// Board circuitry on the port pins
`timescale 1ns/10ps
`default_nettype none
module standby_board_model
(
  // Pin side of the block
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup,
  // External drivers
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  // Resolved levels
  output logic [7:0] pin_in
);
  // Undriven pins settle on pull-up or board pull-down
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
    | (~pin_oe & ~ext_en & pin_pullup);
endmodule
`default_nettype wire

// [tb_standby_pin_state_control.sv]
// Self-checking testbench for the standby pin state control block
`timescale 1ns/10ps
`default_nettype none
`include "standby_pin_defines.svh"
module tb_standby_pin_state_control
  import standby_pin_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, ext_en = 8'h00, ext_val = 8'h00;
  logic [7:0] touch_signal = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic cmp_out_sig = 1'b0, beep_sig = 1'b0, tsc_dout_sig = 1'b0, sense_clock_out = 1'b0;
  logic cmp_analog_event = 1'b0, wake_req = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, cmp_irq, touch_irq, in_standby;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] pin_in, pin_out, pin_oe, pin_pullup, func_in, ext_irq_req;
  int n_fail = 0, check_count = 0, n_ext = 0, n_cmp = 0, n_touch = 0;

  always #50 aclk = ~aclk;

  standby_pin_state_control i_standby_pin_state_control (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .cmp_out_sig(cmp_out_sig), .beep_sig(beep_sig),
    .tsc_dout_sig(tsc_dout_sig), .sense_clock_out(sense_clock_out),
    .cmp_analog_event(cmp_analog_event), .touch_signal(touch_signal), .wake_req(wake_req),
    .func_in(func_in), .ext_irq_req(ext_irq_req), .cmp_irq(cmp_irq), .touch_irq(touch_irq),
    .in_standby(in_standby));
  standby_board_model i_standby_board_model (.pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

  always @(posedge aclk)
  begin
    if (ext_irq_req[5] === 1'b1) n_ext <= n_ext + 1;
    if (cmp_irq === 1'b1) n_cmp <= n_cmp + 1;
    if (touch_irq === 1'b1) n_touch <= n_touch + 1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task idle(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR at %0t got %h expected %h", $time, g, e);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b0;
    chk({awready, wready}, 2'b11);
    chk(bresp, `SPC_RESP_OKAY);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b0;
    chk(arready, 1'b1);
    chk(rdata, e);
    chk(rresp, r);
  endtask

  task mode(input logic [7:0] c);
    wr(`SPC_OFF_CTRL, c);
    idle(2);
  endtask

  task wake;
    @(posedge aclk);
    wake_req <= 1'b1;
    @(posedge aclk);
    wake_req <= 1'b0;
    idle(2);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task t_reset(input int n);
    @(posedge aclk);
    aresetn <= 1'b0;
    ext_en <= 8'h20;
    ext_val <= 8'h20;
    idle(n);
    chk(pin_oe, 8'h00);
    chk(func_in, 8'h00);
    chk(pin_out, 8'h00);
    @(posedge aclk);
    aresetn <= 1'b1;
    rd(`SPC_OFF_STATUS, st_normal, `SPC_RESP_OKAY);
    $display("test reset done");
  endtask

  task t_port;
    wr(`SPC_OFF_PORT_DIR, 8'h08);
    wr(`SPC_OFF_PORT_OUT, 8'h08);
    idle(2);
    chk({pin_oe[3], pin_out[3]}, 2'b11);
    rd(`SPC_OFF_PORT_IN, 8'h28, `SPC_RESP_OKAY);
    rd(8'h40, 32'h00000000, `SPC_RESP_SLVERR);
    $display("test port done");
  endtask

  task t_sleep;
    mode(8'h02);
    chk(in_standby, 1'b0);
    chk({pin_oe[3], func_in}, 9'h128);
    rd(`SPC_OFF_STATUS, st_sleep, `SPC_RESP_OKAY);
    wake;
    mode(8'h02);
    mode(8'h00);
    rd(`SPC_OFF_STATUS, st_normal, `SPC_RESP_OKAY);
    $display("test sleep done");
  endtask

  task t_stop;
    mode(8'h04);
    chk(func_in, 8'h00);
    chk({pin_oe[3], pin_out[3]}, 2'b11);
    wr(`SPC_OFF_PORT_OUT, 8'h00);
    idle(2);
    chk(pin_out[3], 1'b1);
    rd(`SPC_OFF_STATUS, st_stop, `SPC_RESP_OKAY);
    wake;
    chk(pin_out[3], 1'b0);
    rd(`SPC_OFF_STATUS, st_normal, `SPC_RESP_OKAY);
    $display("test stop done");
  endtask

  task t_watch;
    wr(`SPC_OFF_PULLUP, 8'h08);
    mode(8'h07);
    chk(pin_oe[3], 1'b0);
    chk(pin_pullup, 8'h08);
    rd(`SPC_OFF_STATUS, st_watch, `SPC_RESP_OKAY);
    rd(`SPC_OFF_CTRL, 8'h07, `SPC_RESP_OKAY);
    wake;
    $display("test watch done");
  endtask

  task t_func;
    @(posedge aclk);
    cmp_out_sig <= 1'b1;
    tsc_dout_sig <= 1'b1;
    wr(`SPC_OFF_FUNC, 8'h07);
    mode(8'h04);
    chk({pin_oe[2:0], pin_out[2:0]}, 6'h3D);
    @(posedge aclk);
    beep_sig <= 1'b1;
    idle(2);
    chk(pin_out[1], 1'b1);
    wake;
    mode(8'h05);
    chk(pin_oe[2:0], 3'h0);
    wake;
    $display("test function pins done");
  endtask

  task t_touch;
    @(posedge aclk);
    sense_clock_out <= 1'b1;
    wr(`SPC_OFF_FUNC, 8'h08);
    wr(`SPC_OFF_TOUCH_SEL, 8'h10);
    mode(8'h05);
    chk({pin_oe[5:4], pin_out[4]}, 3'h3);
    wake;
    $display("test touch done");
  endtask

  task t_irq;
    @(posedge aclk);
    ext_val <= 8'h00;
    wr(`SPC_OFF_EXTINT_EN, 8'h20);
    wr(`SPC_OFF_FUNC, 8'h30);
    mode(8'h04);
    @(posedge aclk);
    ext_val <= 8'h20;
    idle(3);
    chk({n_ext[30:0], in_standby}, 32'h2);
    mode(8'h04);
    @(posedge aclk);
    cmp_analog_event <= 1'b1;
    @(posedge aclk);
    cmp_analog_event <= 1'b0;
    idle(2);
    chk({n_cmp[30:0], in_standby}, 32'h2);
    mode(8'h06);
    @(posedge aclk);
    touch_signal <= 8'h10;
    idle(3);
    chk({n_touch[30:0], in_standby}, 32'h2);
    $display("test interrupts done");
  endtask

  task finish_test;
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    t_reset(18);
    t_port;
    t_sleep;
    t_stop;
    t_watch;
    t_func;
    t_touch;
    t_irq;
    t_reset(3);
    finish_test;
  end

  initial
  begin
    repeat (3000) @(posedge aclk);
    n_fail++;
    finish_test;
  end
endmodule
`default_nettype wire
